//--- src/sstseq_pkg.sv
// Package of constants and carrier types for the sweep trigger sequencer
package sstseq_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL   = 12'h0000;
  localparam logic [11:0] ADDR_LENGTH = 12'h0004;
  localparam logic [11:0] ADDR_DELAY  = 12'h0008;
  localparam logic [11:0] ADDR_STATUS = 12'h000C;

  // ==========================================================
  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;   // Two bits of trigger mode
  localparam int CTRL_SLOW_BIT  = 2;   // Slow sweep select
  localparam int CTRL_SLAVE_BIT = 3;   // 0 selects X slave, 1 selects Y slave

  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_03E8;
  localparam logic [31:0] DELAY_RESET  = 32'h0000_01F4;

  // ==========================================================
  // Timing: the squarer level sampled each ref_clk cycle
  localparam int SHAPE_LEVEL_BITS = 8;
  localparam int LENGTH_BITS      = 24;

  // Trigger modes
  typedef enum logic [1:0] {
    SSTSEQ_MODE_RATE     = 2'b00,
    SSTSEQ_MODE_INTERNAL = 2'b01,
    SSTSEQ_MODE_EXTERNAL = 2'b10
  } sstseq_mode_t;

  // Main element states, Gray along the path off then on
  typedef enum logic [0:0] {
    SSTSEQ_OFF = 1'b0,
    SSTSEQ_ON  = 1'b1
  } sstseq_state_t;

  // Trigger inputs that travel together
  typedef struct packed {
    logic master;
    logic slave_x;
    logic slave_y;
  } sstseq_trig_t;

endpackage

//--- src/sstseq_top.sv
// Sweep trigger sequencer: input gate, main element, ramp, trace shift, delay
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module sstseq_top #(
  parameter int LENGTH_BITS = sstseq_pkg::LENGTH_BITS,
  parameter int LEVEL_BITS  = sstseq_pkg::SHAPE_LEVEL_BITS
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Receiver triggers (pins)
  input  wire sstseq_pkg::sstseq_trig_t   trig_in,
  // Internal or external signal level for the squarer
  input  wire logic [LEVEL_BITS-1:0]      shape_level,
  input  wire logic [LEVEL_BITS-1:0]      shape_threshold,
  // Sweep outputs
  output logic                            sweep_gate,
  output logic                            trace_blank_n,
  output logic                            lower_trace,
  output logic      [LENGTH_BITS-1:0]     ramp
);

  // ==========================================================
  // Registers and state
  logic [31:0]                ctrl;
  logic [LENGTH_BITS-1:0]     sweep_length;
  logic [LENGTH_BITS-1:0]     delay_length;
  logic [LENGTH_BITS-1:0]     delay_cnt;
  logic                       delay_run;
  sstseq_pkg::sstseq_state_t  main_state;
  logic                       shift_q;
  sstseq_pkg::sstseq_trig_t   trig_s1;
  sstseq_pkg::sstseq_trig_t   trig_s2;
  sstseq_pkg::sstseq_trig_t   trig_d;
  logic [LEVEL_BITS-1:0]      lvl_s1;
  logic [LEVEL_BITS-1:0]      lvl_s2;
  logic                       above_d;
  logic                       main_on;
  sstseq_pkg::sstseq_mode_t   mode;
  logic                       slow;
  logic                       trig_mode;
  logic                       master_edge;
  logic                       slave_edge;
  logic                       gate_pulse;
  logic                       shape_pulse;
  logic                       delay_pulse;
  logic                       start;
  logic                       level_hit;
  logic                       wr_en;

  assign mode      = sstseq_pkg::sstseq_mode_t'(ctrl[sstseq_pkg::CTRL_MODE_LSB +: 2]);
  assign slow      = ctrl[sstseq_pkg::CTRL_SLOW_BIT];
  assign trig_mode = (mode != sstseq_pkg::SSTSEQ_MODE_RATE);
  assign main_on   = (main_state == sstseq_pkg::SSTSEQ_ON);

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_s1 <= '0;
      trig_s2 <= '0;
      trig_d  <= '0;
      lvl_s1  <= '0;
      lvl_s2  <= '0;
    end else begin
      trig_s1 <= trig_in;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
      lvl_s1  <= shape_level;
      lvl_s2  <= lvl_s1;
    end
  end

  // ==========================================================
  // Rising edge of a level against its value one cycle earlier
  function automatic logic rise(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  // Summation gate: master plus selected slave, rising edges only
  assign master_edge = rise(trig_s2.master, trig_d.master);
  assign slave_edge  = ctrl[sstseq_pkg::CTRL_SLAVE_BIT] ?
                       rise(trig_s2.slave_y, trig_d.slave_y) :
                       rise(trig_s2.slave_x, trig_d.slave_x);
  // Blocked in trigger modes, slave blocked in slow; inputs are only read
  assign gate_pulse  = ~trig_mode & (master_edge | (slave_edge & ~slow));

  // Squarer: crossing the threshold in trigger modes makes one pulse
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      above_d <= 1'b0;
    end else begin
      above_d <= (lvl_s2 > shape_threshold);
    end
  end
  assign shape_pulse = trig_mode & rise(lvl_s2 > shape_threshold, above_d);

  // ==========================================================
  // Main element: three start sources, one stop source
  assign start     = gate_pulse | delay_pulse | shape_pulse;
  assign level_hit = main_on & (ramp >= sweep_length);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_state <= sstseq_pkg::SSTSEQ_OFF;
    end else begin
      case (main_state)
        sstseq_pkg::SSTSEQ_OFF: begin
          if (start) begin
            main_state <= sstseq_pkg::SSTSEQ_ON;
          end
        end
        default: begin
          // Starts ignored; only the level detector ends the sweep
          if (level_hit) begin
            main_state <= sstseq_pkg::SSTSEQ_OFF;
          end
        end
      endcase
    end
  end

  // Ramp runs while on, held discharged while off
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ramp <= '0;
    end else if (main_on && !level_hit) begin
      ramp <= ramp + 1'b1;
    end else begin
      // Discharged at the stop edge too, so no stale top shows while off
      ramp <= '0;
    end
  end

  assign sweep_gate    = main_on;
  assign trace_blank_n = main_on;

  // ==========================================================
  // Trace shift toggles on each start; master start selects top trace
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= 1'b0;
    end else if (!main_on && start) begin
      if (master_edge && !trig_mode) begin
        shift_q <= 1'b0;
      end else begin
        shift_q <= ~shift_q;
      end
    end
  end
  assign lower_trace = shift_q;

  // ==========================================================
  // Slow mode delay one-shot, fired by the top trace start
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      delay_run <= 1'b0;
      delay_cnt <= '0;
    end else if (!main_on && start && slow && !trig_mode
                 && master_edge) begin
      delay_run <= 1'b1;
      delay_cnt <= delay_length;
    end else if (delay_run && !main_on) begin
      // Delay counts after the top trace ends
      if (delay_cnt == '0) begin
        delay_run <= 1'b0;
      end else begin
        delay_cnt <= delay_cnt - 1'b1;
      end
    end
  end
  assign delay_pulse = delay_run & ~main_on & (delay_cnt == '0) & slow;

  // ==========================================================
  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl         <= sstseq_pkg::CTRL_RESET;
      sweep_length <= sstseq_pkg::LENGTH_RESET[LENGTH_BITS-1:0];
      delay_length <= sstseq_pkg::DELAY_RESET[LENGTH_BITS-1:0];
    end else if (wr_en) begin
      if (paddr == sstseq_pkg::ADDR_CTRL) begin
        ctrl <= {28'h000_0000, pwdata[3:0]};
      end else if (paddr == sstseq_pkg::ADDR_LENGTH) begin
        sweep_length <= pwdata[LENGTH_BITS-1:0];
      end else if (paddr == sstseq_pkg::ADDR_DELAY) begin
        delay_length <= pwdata[LENGTH_BITS-1:0];
      end
    end
  end

  // Read data registered on setup so it is valid in the access phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == sstseq_pkg::ADDR_CTRL) begin
        prdata <= ctrl;
      end else if (paddr == sstseq_pkg::ADDR_LENGTH) begin
        prdata <= {{(32-LENGTH_BITS){1'b0}}, sweep_length};
      end else if (paddr == sstseq_pkg::ADDR_DELAY) begin
        prdata <= {{(32-LENGTH_BITS){1'b0}}, delay_length};
      end else if (paddr == sstseq_pkg::ADDR_STATUS) begin
        prdata <= {29'h0000_0000, delay_run, shift_q, main_on};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Checks
  // Input gate
  blocked_mode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_mode |-> !gate_pulse)
    else $error("trigger passed in trigger mode");
  slave_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && slave_edge && !trig_mode && !slow) |=> main_on)
    else $error("selected slave did not start sweep");
  slow_slave_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (slow && !master_edge && !delay_pulse && !shape_pulse) |-> !start)
    else $error("slave started slow sweep");

  // Main element and ramp
  start_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && start) |=> main_on)
    else $error("start did not switch on");
  main_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && !start) |=> !main_on)
    else $error("sweep began without a start source");
  level_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    level_hit |=> !main_on)
    else $error("level detector did not stop sweep");
  level_rearm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    level_hit |=> (!main_on && ramp == '0))
    else $error("sweep not rearmed after stop");
  hold_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (main_on && !level_hit) |=> main_on)
    else $error("sweep ended early");
  ramp_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (main_on && !level_hit) |=> (ramp == $past(ramp) + 1'b1))
    else $error("ramp did not advance");
  ramp_rest_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !main_on |-> (ramp == '0))
    else $error("ramp not at rest");
  blank_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && start) |=> (sweep_gate && trace_blank_n))
    else $error("ramp gate or unblank missing");

  // Trace shift and delay one-shot
  shift_toggle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && start && !master_edge) |=> (shift_q != $past(shift_q)))
    else $error("trace shift did not toggle");
  master_top_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && master_edge && !trig_mode) |=> (main_on && !shift_q))
    else $error("master start not on top trace");
  delay_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (delay_pulse && !master_edge) |=> (main_on && shift_q != $past(shift_q)))
    else $error("one-shot did not start lower trace");
  oneshot_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !slow |-> !delay_pulse)
    else $error("one-shot fired outside slow");

  // Squarer
  shaper_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !trig_mode |-> !shape_pulse)
    else $error("shaper active in rate mode");
  shape_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!main_on && shape_pulse) |=> main_on)
    else $error("shaped pulse did not start sweep");

endmodule

`default_nettype wire

//--- testbench/sstseq_rcv_model.sv
// Receiver model issuing master and slave trigger pulses
`timescale 1ns/10ps
`default_nettype none
module sstseq_rcv_model #(
  parameter int WIDTH = 3
) (
  // Clock
  input  wire logic                     ref_clk,
  // Trigger pins toward the sequencer
  output var  sstseq_pkg::sstseq_trig_t trig
);
  logic master_next = 1'b1;

  // ======
  // Pulses alternate master then slave, idle low between pulses
  initial trig = '0;
  task automatic send(input logic use_y);
    sstseq_pkg::sstseq_trig_t p;
    p = '0;
    if (master_next) p.master = 1'b1;
    else if (use_y) p.slave_y = 1'b1;
    else p.slave_x = 1'b1;
    master_next = !master_next;
    trig <= p;
    repeat (WIDTH) @(posedge ref_clk);
    trig <= '0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/sstseq_top_bench.sv
// Self-checking bench for the sweep trigger sequencer
`timescale 1ns/10ps
`default_nettype none
module sstseq_top_bench;
  localparam logic [31:0] LEN = 32'h0000_000A;
  localparam logic [31:0] DLY = 32'h0000_0005;
  logic                     ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic                     sweep_gate, trace_blank_n, lower_trace, lt_seen;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, seed, res;
  logic [7:0]               shape_level, shape_threshold;
  logic [23:0]              ramp, ramp_top;
  sstseq_pkg::sstseq_trig_t trig_in;
  logic [31:0]              rd_q[$], sw_q[$];
  int                       dur, failures, compares;

  // ======
  // Design and receiver model
  sstseq_top sstseq_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .shape_level(shape_level),
    .shape_threshold(shape_threshold), .sweep_gate(sweep_gate), .trace_blank_n(trace_blank_n),
    .lower_trace(lower_trace), .ramp(ramp));
  sstseq_rcv_model sstseq_rcv_model_inst (.ref_clk(ref_clk), .trig(trig_in));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Comparison, verdict and helpers
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // APB transfer held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // Expected sweep: trace, top ramp value, cycles on
  task automatic sweep(input logic lt);
    sw_q.push_back({lt, LEN[14:0], LEN[15:0] + 16'h0001});
  endtask
  // Noisy level below threshold, then one rising crossing
  task automatic shape;
    repeat (6) begin
      seed = xs(seed);
      shape_level <= {1'b0, seed[6:0]};
      @(posedge ref_clk);
    end
    shape_level <= 8'hF0;
    idle(4);
    shape_level <= 8'h00;
    idle(20);
  endtask

  // Results as they appear, against the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("prdata", prdata, rd_q.size() != 0 ? rd_q.pop_front() : '1);
    end
    if (psel && penable && pready === 1'b1) begin
      check("pslverr", 32'(pslverr), 32'h0000_0000);
    end
    if (sweep_gate === 1'b1) begin
      check("trace_blank_n", 32'(trace_blank_n), 32'h0000_0001);
      dur++;
      ramp_top = ramp;
      lt_seen = lower_trace;
    end else begin
      check("ramp", 32'(ramp), 32'h0000_0000);
      check("trace_blank_n", 32'(trace_blank_n), 32'h0000_0000);
      if (dur != 0) begin
        res = {lt_seen, ramp_top[14:0], dur[15:0]};
        check("sweep", res, sw_q.size() != 0 ? sw_q.pop_front() : '1);
        dur = 0;
      end
    end
  end

  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite} = 4'b1000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    shape_level = 8'h00;
    seed = 32'h0000_A1F9;
    seed = xs(seed);
    // Random threshold kept above the noise and below the crossing level
    shape_threshold <= {2'b10, seed[5:0]};
    idle(20);
    check("lower_trace", 32'(lower_trace), 32'h0000_0000);
    sys_rst <= 1'b0;
    idle(1);
    rd(sstseq_pkg::ADDR_LENGTH, sstseq_pkg::LENGTH_RESET);
    rd(sstseq_pkg::ADDR_DELAY, sstseq_pkg::DELAY_RESET);
    rd(12'h010, 32'h0000_0000);
    rd(sstseq_pkg::ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, sstseq_pkg::ADDR_LENGTH, LEN);
    apb(1'b1, sstseq_pkg::ADDR_DELAY, DLY);
    rd(sstseq_pkg::ADDR_LENGTH, LEN);
    sweep(1'b0);
    sstseq_rcv_model_inst.send(1'b0);
    sstseq_rcv_model_inst.send(1'b0);
    idle(20);
    sweep(1'b0);
    sstseq_rcv_model_inst.send(1'b0);
    idle(20);
    sweep(1'b1);
    sstseq_rcv_model_inst.send(1'b0);
    idle(20);
    sweep(1'b0);
    sstseq_rcv_model_inst.send(1'b0);
    idle(20);
    sstseq_rcv_model_inst.send(1'b1);
    shape;
    apb(1'b1, sstseq_pkg::ADDR_CTRL, 32'h0000_0001);
    sstseq_rcv_model_inst.send(1'b0);
    sstseq_rcv_model_inst.send(1'b0);
    sweep(1'b1);
    shape;
    apb(1'b1, sstseq_pkg::ADDR_CTRL, 32'h0000_0002);
    sstseq_rcv_model_inst.send(1'b0);
    sstseq_rcv_model_inst.send(1'b1);
    sweep(1'b0);
    shape;
    apb(1'b1, sstseq_pkg::ADDR_CTRL, 32'h0000_0004);
    sweep(1'b0);
    sweep(1'b1);
    sstseq_rcv_model_inst.send(1'b0);
    idle(40);
    sstseq_rcv_model_inst.send(1'b0);
    idle(40);
    check("pending", 32'(rd_q.size() + sw_q.size()), 32'h0000_0000);
    end_sim;
  end

  // Watchdog
  initial begin
    idle(3000);
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
